// ### hdl/output_driver_pkg.sv
// Constants, register map and carrier types for the output driver control block
// Overview of operation
// - Speaker analog volume spans 0 dB to about -78 dB in half steps, soft-stepped.
// - Page 1 offset 38 bits 6..0 hold the speaker volume attenuation code.
// - Page 1 offset 35 bits 7..6 route the DAC output into the volume stage.
// - Page 1 offset 38 bit 7 connects the volume stage output to the speaker amplifier.
// - Page 0 offset 63 bits 1..0 select the soft-stepping interval.
// - Writing 11 to page 1 offset 44 bits 2..1 selects power-optimised lineout mode.
// - Page 1 offset 31 bits 4..3 select one of four output common-mode levels.
// - Page 1 offset 31 bit 7 powers the headphone driver on or off.
// - Page 1 offset 40 bits 6..3 set headphone gain, bit 2 mutes it.
// - On headphone short, bit 1 of offset 31 picks current limit (0) or power-down (1).
// - A headphone short is shown by read-only bit 0 of page 1 offset 31.
// - In shutdown mode a headphone short clears the headphone power bit at once.
// - Setting the headphone power bit again re-enables; a lasting fault shuts down again.
// - Pin or software master reset restores all defaults, clearing both power bits and both fault flags.
// - Page 1 offset 32 bit 7 powers the class-D speaker driver on or off.
// - Page 1 offset 42 bits 4..3 set speaker gain, bit 2 mutes it.
// - Speaker overcurrent always shuts the stage down; flag at page 1 offset 32 bit 0.
// - Setting the speaker power bit again re-enables; a lasting fault shuts down again.
// - Over-temperature stops speaker switching until cool; flag at page 0 offset 3 bit 1.
// - Volume output is muted when routing bit 7 is 0 and the code is 127.
package output_driver_pkg;

  // Register offsets (page 0)
  localparam logic [7:0] OFS_PAGE_SEL = 8'h00;
  localparam logic [7:0] OFS_SOFT_RESET = 8'h01;
  localparam logic [7:0] OFS_OVERTEMP_FLAG = 8'h03;
  localparam logic [7:0] OFS_VOLUME_STEP_TIME = 8'h3F;
  // Register offsets (page 1)
  localparam logic [7:0] OFS_HP_POWER_CTRL = 8'h1F;
  localparam logic [7:0] OFS_SPK_POWER_CTRL = 8'h20;
  localparam logic [7:0] OFS_DAC_VOLUME_ROUTING = 8'h23;
  localparam logic [7:0] OFS_SPK_VOLUME = 8'h26;
  localparam logic [7:0] OFS_HP_GAIN_MUTE = 8'h28;
  localparam logic [7:0] OFS_SPK_GAIN_MUTE = 8'h2A;
  localparam logic [7:0] OFS_HP_DRIVE_MODE = 8'h2C;
  localparam logic [7:0] PAGE_0 = 8'h00;
  localparam logic [7:0] PAGE_1 = 8'h01;

  // Field positions
  localparam int BIT_POWER = 7;
  localparam int BIT_HP_SHUTDOWN = 1;
  localparam int BIT_FAULT = 0;
  localparam int BIT_OVERTEMP = 1;
  localparam int BIT_SW_RESET = 0;
  localparam int BIT_VOL_ROUTE = 7;
  localparam int BIT_MUTE = 2;

  // Reset values
  localparam logic [6:0] RST_SPK_VOLUME = 7'h7F;
  localparam logic [1:0] RST_FIELD2 = 2'h0;
  localparam logic [3:0] RST_HP_GAIN = 4'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Codes
  localparam logic [6:0] VOL_MUTE_CODE = 7'h7F;
  localparam logic [1:0] LINEOUT_MODE_CODE = 2'h3;
  localparam logic [1:0] STEP_ONE_PERIOD = 2'h0;
  localparam logic [1:0] STEP_TWO_PERIODS = 2'h1;

  // Soft-step base interval: one audio frame at 48 kHz, rounded up to clock cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_TIME_NS = 20834;
  localparam int STEP_BASE_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_CNT_W = 14;

  // Fault detector levels from the analog stages
  typedef struct packed {
    logic hpShort;
    logic spkOverCurrent;
    logic overTemp;
  } fault_in_t;

  // Register access request
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wrData;
  } reg_req_t;

endpackage

// ### hdl/soft_step.sv
// Soft-stepping engine: walks the applied volume code toward its target
`timescale 1ns/10ps
module soft_step
  import output_driver_pkg::*;
#(
  parameter int BaseCycles = STEP_BASE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic [6:0] target,
  input wire logic [1:0] stepSel,
  output logic [6:0] applied,
  output logic busy
);

  typedef struct packed {
    logic [6:0] applied;
    logic [STEP_CNT_W-1:0] cnt;
  } step_state_t;

  step_state_t s_q, s_d;
  logic [STEP_CNT_W-1:0] interval;

  // Interval per step; codes 2 and 3 switch stepping off and jump at once
  always_comb begin
    s_d = s_q;
    interval = STEP_CNT_W'(BaseCycles);
    if (stepSel == STEP_TWO_PERIODS) begin
      interval = STEP_CNT_W'(2 * BaseCycles);
    end
    if (clear) begin
      s_d.applied = RST_SPK_VOLUME;
      s_d.cnt = '0;
    end else if (s_q.applied == target) begin
      s_d.cnt = '0;
    end else if (stepSel != STEP_ONE_PERIOD && stepSel != STEP_TWO_PERIODS) begin
      s_d.applied = target;
      s_d.cnt = '0;
    end else if (s_q.cnt >= interval - 1'b1) begin
      s_d.cnt = '0;
      if (s_q.applied < target) begin
        s_d.applied = s_q.applied + 7'h01;
      end else begin
        s_d.applied = s_q.applied - 7'h01;
      end
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '{applied: RST_SPK_VOLUME, cnt: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign applied = s_q.applied;
  assign busy = (s_q.applied != target);

endmodule

// ### hdl/stage_guard.sv
// Power bit and fault flag keeper for one output stage
`timescale 1ns/10ps
module stage_guard (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic powerWrite,
  input wire logic powerValue,
  input wire logic fault,
  input wire logic shutdownMode,
  output logic powerOn,
  output logic faultFlag,
  output logic currentLimit
);

  typedef struct packed {
    logic power;
    logic flag;
    logic limit;
  } guard_state_t;

  guard_state_t g_q, g_d;

  // A software write lands first; in shutdown mode a lasting fault knocks the bit down next cycle
  always_comb begin
    g_d = g_q;
    if (clear) begin
      g_d = '0;
    end else begin
      if (powerWrite) begin
        g_d.power = powerValue;
        if (powerValue) begin
          g_d.flag = 1'b0;
        end
      end else if (fault && shutdownMode && g_q.power) begin
        g_d.power = 1'b0;
      end
      if (fault && g_q.power) begin
        g_d.flag = 1'b1;
      end
      g_d.limit = fault && !shutdownMode && g_d.power;
    end
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      g_q <= '0;
    end else begin
      g_q <= g_d;
    end
  end

  assign powerOn = g_q.power;
  assign faultFlag = g_q.flag;
  assign currentLimit = g_q.limit;

endmodule

// ### hdl/output_driver_control.sv
// Paged control registers and protection for the headphone and speaker drivers
`timescale 1ns/10ps
module output_driver_control
  import output_driver_pkg::*;
#(
  parameter int StepCycles = STEP_BASE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire reg_req_t regReq,
  input wire fault_in_t faultIn,
  output logic [7:0] regRdData,
  output logic regRdValid,
  output logic [1:0] dacVolRoute,
  output logic volToSpkRoute,
  output logic [6:0] spkVolApplied,
  output logic spkVolMuted,
  output logic spkVolBusy,
  output logic hpPowerOn,
  output logic hpCurrentLimit,
  output logic [3:0] hpGain,
  output logic hpMute,
  output logic [1:0] hpCommonMode,
  output logic lineoutMode,
  output logic spkPowerOn,
  output logic spkSwitchEn,
  output logic [1:0] spkGain,
  output logic spkMute
);

  // Software-visible and output state held here; power bits, fault flags and applied volume live in the submodules
  typedef struct packed {
    logic [7:0] page;
    logic swReset;
    logic [1:0] stepSel;
    logic [1:0] hpCm;
    logic hpShutMode;
    logic [1:0] dacRoute;
    logic volRoute;
    logic [6:0] spkVol;
    logic [3:0] hpGain;
    logic hpMute;
    logic [1:0] spkGain;
    logic spkMute;
    logic [1:0] hpDrive;
    logic [7:0] rdData;
    logic rdValid;
    logic volMuted;
    logic spkSwitch;
    logic lineout;
  } ctrl_state_t;

  localparam ctrl_state_t CTRL_RESET = '{
    page: PAGE_0,
    swReset: 1'b0,
    stepSel: RST_FIELD2,
    hpCm: RST_FIELD2,
    hpShutMode: 1'b0,
    dacRoute: RST_FIELD2,
    volRoute: 1'b0,
    spkVol: RST_SPK_VOLUME,
    hpGain: RST_HP_GAIN,
    hpMute: 1'b1,
    spkGain: RST_FIELD2,
    spkMute: 1'b1,
    hpDrive: RST_FIELD2,
    rdData: RST_BYTE,
    rdValid: 1'b0,
    volMuted: 1'b1,
    spkSwitch: 1'b0,
    lineout: 1'b0
  };

  ctrl_state_t c_q, c_d;

  logic hpPowerBit;
  logic hpFaultFlag;
  logic hpLimit;
  logic spkPowerBit;
  logic spkFaultFlag;
  logic spkLimitUnused;
  logic [6:0] volApplied;
  logic volBusy;
  logic hpPowerWrite;
  logic spkPowerWrite;

  // Page and offset match, shared by the write and read decoders
  function automatic logic regHit(input logic [7:0] curPage, input logic [7:0] addr,
                                  input logic [7:0] wantPage, input logic [7:0] wantAddr);
    // Page select sits at offset zero of every page
    regHit = (addr == wantAddr) && (curPage == wantPage || wantAddr == OFS_PAGE_SEL);
  endfunction

  // Power bit writes go to the guards so the fault logic sees them the same cycle
  assign hpPowerWrite = regReq.write && !c_q.swReset
                        && regHit(c_q.page, regReq.addr, PAGE_1, OFS_HP_POWER_CTRL);
  assign spkPowerWrite = regReq.write && !c_q.swReset
                         && regHit(c_q.page, regReq.addr, PAGE_1, OFS_SPK_POWER_CTRL);

  // Headphone stage: shutdown or current limit chosen by software
  stage_guard u_hp_guard (
    .clk(clk),
    .reset(reset),
    .clear(c_q.swReset),
    .powerWrite(hpPowerWrite),
    .powerValue(regReq.wrData[BIT_POWER]),
    .fault(faultIn.hpShort),
    .shutdownMode(c_q.hpShutMode),
    .powerOn(hpPowerBit),
    .faultFlag(hpFaultFlag),
    .currentLimit(hpLimit)
  );

  // Speaker stage has no current-limit option, so shutdown mode is tied on
  stage_guard u_spk_guard (
    .clk(clk),
    .reset(reset),
    .clear(c_q.swReset),
    .powerWrite(spkPowerWrite),
    .powerValue(regReq.wrData[BIT_POWER]),
    .fault(faultIn.spkOverCurrent),
    .shutdownMode(1'b1),
    .powerOn(spkPowerBit),
    .faultFlag(spkFaultFlag),
    .currentLimit(spkLimitUnused)
  );

  // Speaker analog volume soft-stepping
  soft_step #(
    .BaseCycles(StepCycles)
  ) u_spk_step (
    .clk(clk),
    .reset(reset),
    .clear(c_q.swReset),
    .target(c_q.spkVol),
    .stepSel(c_q.stepSel),
    .applied(volApplied),
    .busy(volBusy)
  );

  // Register writes, read mux and derived outputs
  always_comb begin
    c_d = c_q;
    c_d.swReset = 1'b0;
    c_d.rdValid = 1'b0;
    if (c_q.swReset) begin
      // Software reset restores every field one cycle after the write
      c_d = CTRL_RESET;
    end else begin
      if (regReq.write) begin
        if (regHit(c_q.page, regReq.addr, PAGE_0, OFS_PAGE_SEL)) begin
          c_d.page = regReq.wrData;
        end
        if (regHit(c_q.page, regReq.addr, PAGE_0, OFS_SOFT_RESET)) begin
          c_d.swReset = regReq.wrData[BIT_SW_RESET];
        end
        if (regHit(c_q.page, regReq.addr, PAGE_0, OFS_VOLUME_STEP_TIME)) begin
          c_d.stepSel = regReq.wrData[1:0];
        end
        if (regHit(c_q.page, regReq.addr, PAGE_1, OFS_HP_POWER_CTRL)) begin
          c_d.hpCm = regReq.wrData[4:3];
          c_d.hpShutMode = regReq.wrData[BIT_HP_SHUTDOWN];
        end
        if (regHit(c_q.page, regReq.addr, PAGE_1, OFS_DAC_VOLUME_ROUTING)) begin
          c_d.dacRoute = regReq.wrData[7:6];
        end
        if (regHit(c_q.page, regReq.addr, PAGE_1, OFS_SPK_VOLUME)) begin
          c_d.volRoute = regReq.wrData[BIT_VOL_ROUTE];
          c_d.spkVol = regReq.wrData[6:0];
        end
        if (regHit(c_q.page, regReq.addr, PAGE_1, OFS_HP_GAIN_MUTE)) begin
          c_d.hpGain = regReq.wrData[6:3];
          c_d.hpMute = regReq.wrData[BIT_MUTE];
        end
        if (regHit(c_q.page, regReq.addr, PAGE_1, OFS_SPK_GAIN_MUTE)) begin
          c_d.spkGain = regReq.wrData[4:3];
          c_d.spkMute = regReq.wrData[BIT_MUTE];
        end
        if (regHit(c_q.page, regReq.addr, PAGE_1, OFS_HP_DRIVE_MODE)) begin
          c_d.hpDrive = regReq.wrData[2:1];
        end
      end
      // Reads return live flags; unmapped offsets read as zero
      if (regReq.read) begin
        c_d.rdValid = 1'b1;
        c_d.rdData = RST_BYTE;
        if (regHit(c_q.page, regReq.addr, PAGE_0, OFS_PAGE_SEL)) begin
          c_d.rdData = c_q.page;
        end
        if (regHit(c_q.page, regReq.addr, PAGE_0, OFS_OVERTEMP_FLAG)) begin
          c_d.rdData[BIT_OVERTEMP] = faultIn.overTemp;
        end
        if (regHit(c_q.page, regReq.addr, PAGE_0, OFS_VOLUME_STEP_TIME)) begin
          c_d.rdData[1:0] = c_q.stepSel;
        end
        if (regHit(c_q.page, regReq.addr, PAGE_1, OFS_HP_POWER_CTRL)) begin
          c_d.rdData[BIT_POWER] = hpPowerBit;
          c_d.rdData[4:3] = c_q.hpCm;
          c_d.rdData[BIT_HP_SHUTDOWN] = c_q.hpShutMode;
          c_d.rdData[BIT_FAULT] = hpFaultFlag;
        end
        if (regHit(c_q.page, regReq.addr, PAGE_1, OFS_SPK_POWER_CTRL)) begin
          c_d.rdData[BIT_POWER] = spkPowerBit;
          c_d.rdData[BIT_FAULT] = spkFaultFlag;
        end
        if (regHit(c_q.page, regReq.addr, PAGE_1, OFS_DAC_VOLUME_ROUTING)) begin
          c_d.rdData[7:6] = c_q.dacRoute;
        end
        if (regHit(c_q.page, regReq.addr, PAGE_1, OFS_SPK_VOLUME)) begin
          c_d.rdData = {c_q.volRoute, c_q.spkVol};
        end
        if (regHit(c_q.page, regReq.addr, PAGE_1, OFS_HP_GAIN_MUTE)) begin
          c_d.rdData[6:3] = c_q.hpGain;
          c_d.rdData[BIT_MUTE] = c_q.hpMute;
        end
        if (regHit(c_q.page, regReq.addr, PAGE_1, OFS_SPK_GAIN_MUTE)) begin
          c_d.rdData[4:3] = c_q.spkGain;
          c_d.rdData[BIT_MUTE] = c_q.spkMute;
        end
        if (regHit(c_q.page, regReq.addr, PAGE_1, OFS_HP_DRIVE_MODE)) begin
          c_d.rdData[2:1] = c_q.hpDrive;
        end
      end
      // Derived outputs follow the registered settings by one cycle
      c_d.volMuted = !c_q.volRoute && (volApplied == VOL_MUTE_CODE);
      c_d.spkSwitch = spkPowerBit && !faultIn.overTemp;
      c_d.lineout = (c_q.hpDrive == LINEOUT_MODE_CODE);
    end
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      c_q <= CTRL_RESET;
    end else begin
      c_q <= c_d;
    end
  end

  // Outputs taken from flip-flops here or inside the submodules; spkVolBusy is a compare of registered values
  assign regRdData = c_q.rdData;
  assign regRdValid = c_q.rdValid;
  assign dacVolRoute = c_q.dacRoute;
  assign volToSpkRoute = c_q.volRoute;
  assign spkVolApplied = volApplied;
  assign spkVolMuted = c_q.volMuted;
  assign spkVolBusy = volBusy;
  assign hpPowerOn = hpPowerBit;
  assign hpCurrentLimit = hpLimit;
  assign hpGain = c_q.hpGain;
  assign hpMute = c_q.hpMute;
  assign hpCommonMode = c_q.hpCm;
  assign lineoutMode = c_q.lineout;
  assign spkPowerOn = spkPowerBit;
  assign spkSwitchEn = c_q.spkSwitch;
  assign spkGain = c_q.spkGain;
  assign spkMute = c_q.spkMute;

endmodule

// ### tb/output_driver_control_properties.sv
// Port-level assertions for the output driver control block
`timescale 1ns/10ps
module output_driver_control_properties
  import output_driver_pkg::*;
#(
  parameter int StepCycles = STEP_BASE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire reg_req_t regReq,
  input wire fault_in_t faultIn,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  input wire logic [6:0] spkVolApplied,
  input wire logic volToSpkRoute,
  input wire logic spkVolMuted,
  input wire logic spkVolBusy,
  input wire logic hpPowerOn,
  input wire logic hpCurrentLimit,
  input wire logic spkPowerOn,
  input wire logic spkSwitchEn
);
  // Slowest interval plus lag; a retarget does not restart the step count
  localparam int WaitMax = 2 * StepCycles + 3;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Reads are skipped only right after a write that may be a software reset
  chk_rd_answer: assert property (regReq.read && !$past(regReq.write) |=> regRdValid)
    else $error("read got no answer");
  chk_rd_quiet: assert property (!regReq.read |=> !regRdValid)
    else $error("answer without read");
  chk_spk_ocp: assert property (
    spkPowerOn && faultIn.spkOverCurrent && !regReq.write |=> !spkPowerOn)
    else $error("speaker stayed on through overcurrent");
  chk_temp_stop: assert property (faultIn.overTemp |=> !spkSwitchEn)
    else $error("speaker switching while hot");
  chk_switch_run: assert property (
    spkPowerOn && !faultIn.overTemp ##1 spkPowerOn |-> spkSwitchEn)
    else $error("speaker not switching while powered and cool");
  chk_hp_short: assert property (
    hpPowerOn && faultIn.hpShort && !regReq.write |=> !hpPowerOn || hpCurrentLimit)
    else $error("headphone short neither limited nor shut down");
  chk_limit_cause: assert property (
    hpCurrentLimit |-> $past(faultIn.hpShort) && hpPowerOn)
    else $error("current limit without short");
  chk_mute_flag: assert property (
    $stable(spkVolApplied) && $stable(volToSpkRoute)
      |-> spkVolMuted == (!volToSpkRoute && spkVolApplied == VOL_MUTE_CODE))
    else $error("volume mute flag wrong");
  chk_vol_hold: assert property (
    !spkVolBusy && !regReq.write && !$past(regReq.write) |=> $stable(spkVolApplied))
    else $error("applied volume moved while settled");
  chk_step_bound: assert property (
    spkVolBusy |-> ##[1:WaitMax] ($changed(spkVolApplied) || !spkVolBusy))
    else $error("soft step stalled");
endmodule

bind output_driver_control output_driver_control_properties #(.StepCycles(StepCycles)) u_chk (
  .clk(clk), .reset(reset), .regReq(regReq), .faultIn(faultIn), .regRdData(regRdData),
  .regRdValid(regRdValid), .spkVolApplied(spkVolApplied), .volToSpkRoute(volToSpkRoute),
  .spkVolMuted(spkVolMuted), .spkVolBusy(spkVolBusy), .hpPowerOn(hpPowerOn),
  .hpCurrentLimit(hpCurrentLimit), .spkPowerOn(spkPowerOn), .spkSwitchEn(spkSwitchEn));

// ### tb/output_driver_control_tb_top.sv
// Self-checking bench for the output driver control block
`timescale 1ns/10ps
module output_driver_control_tb_top;
  import output_driver_pkg::*;
  localparam int Step = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  reg_req_t regReq = '0;
  fault_in_t faultIn = '0;
  logic [7:0] regRdData, r;
  logic [6:0] spkVolApplied;
  logic [3:0] hpGain;
  logic [1:0] dacVolRoute, hpCommonMode, spkGain;
  logic regRdValid, volToSpkRoute, spkVolMuted, spkVolBusy, hpPowerOn, hpCurrentLimit;
  logic hpMute, lineoutMode, spkPowerOn, spkSwitchEn, spkMute;
  logic [7:0] expQ[$];
  int fail_count = 0;
  int total_checks = 0;
  int n, lo, hi;
  integer seed = 32'h92A0545B;

  always #5 clk = ~clk;

  // Short step interval keeps the soft-step walks brief
  output_driver_control #(.StepCycles(Step)) u_dut (.clk(clk), .reset(reset),
    .regReq(regReq), .faultIn(faultIn), .regRdData(regRdData), .regRdValid(regRdValid),
    .dacVolRoute(dacVolRoute), .volToSpkRoute(volToSpkRoute), .spkVolApplied(spkVolApplied),
    .spkVolMuted(spkVolMuted), .spkVolBusy(spkVolBusy), .hpPowerOn(hpPowerOn),
    .hpCurrentLimit(hpCurrentLimit), .hpGain(hpGain), .hpMute(hpMute),
    .hpCommonMode(hpCommonMode), .lineoutMode(lineoutMode), .spkPowerOn(spkPowerOn),
    .spkSwitchEn(spkSwitchEn), .spkGain(spkGain), .spkMute(spkMute));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle strobes; released at the taking edge, so calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    regReq <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    expQ.push_back(e);
    regReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    regReq <= '0;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic summarize();
    // A read that never answered leaves its note behind
    check("rdPending", 8'(expQ.size()), 8'h00);
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Read answers matched against the oldest pending note
  always @(posedge clk) begin
    if (regRdValid === 1'b1) begin
      if (expQ.size() == 0)
        check("rdExtra", 8'h01, 8'h00);
      else
        check("rdData", regRdData, expQ.pop_front());
    end
  end

  // Hang guard; the full sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    #1;
    check("rstVol", {1'b0, spkVolApplied}, 8'h7F);
    check("rstBits", {3'h0, hpMute, spkMute, spkVolMuted, hpPowerOn, spkPowerOn}, 8'h1C);
    wr(OFS_PAGE_SEL, PAGE_1);
    rd(OFS_SPK_VOLUME, 8'h7F);
    rd(OFS_SPK_GAIN_MUTE, 8'h04);
    rd(OFS_HP_POWER_CTRL, 8'h00);
    rd(8'h30, 8'h00);
    $display("done: defaults");
    // Random field values, every drive mode code
    for (int i = 0; i < 4; i++) begin
      r = 8'($random(seed));
      wr(OFS_DAC_VOLUME_ROUTING, r);
      wr(OFS_HP_GAIN_MUTE, r);
      wr(OFS_SPK_GAIN_MUTE, r);
      wr(OFS_HP_POWER_CTRL, {1'b0, r[6:2], 2'b00});
      wr(OFS_HP_DRIVE_MODE, {5'h0, 2'(i), 1'b0});
      // Lineout flag is derived from the stored mode, so it settles one edge later
      cyc(1);
      check("route", {6'h0, dacVolRoute}, {6'h0, r[7:6]});
      check("hpGm", {3'h0, hpGain, hpMute}, {3'h0, r[6:2]});
      check("spkGm", {5'h0, spkGain, spkMute}, {5'h0, r[4:2]});
      check("cmLine", {5'h0, hpCommonMode, lineoutMode}, {5'h0, r[4:3], i == 3});
    end
    $display("done: fields");
    // Every step interval code; the target alternates three codes apart
    for (int s = 0; s < 4; s++) begin
      wr(OFS_PAGE_SEL, PAGE_0);
      wr(OFS_VOLUME_STEP_TIME, 8'(s));
      wr(OFS_PAGE_SEL, PAGE_1);
      r = (s % 2 == 0) ? 8'hFC : 8'hFF;
      lo = (s < 2) ? 2 * Step * (s + 1) : 0;
      hi = (s < 2) ? 3 * Step * (s + 1) + 1 : 2;
      wr(OFS_SPK_VOLUME, r);
      #1;
      check("busyOn", {7'h0, spkVolBusy}, 8'h01);
      n = 0;
      while (spkVolApplied !== r[6:0] && n < 100) begin
        cyc(1);
        n++;
      end
      check("busyOff", {7'h0, spkVolBusy}, 8'h00);
      check("stepCyc", 8'(n >= lo && n <= hi), 8'h01);
      check("muteOff", {6'h0, volToSpkRoute, spkVolMuted}, 8'h02);
      rd(OFS_SPK_VOLUME, r);
    end
    wr(OFS_SPK_VOLUME, 8'h7F);
    cyc(3);
    check("muteOn", {6'h0, volToSpkRoute, spkVolMuted}, 8'h01);
    $display("done: soft step");
    // Headphone short: limit, then shutdown, one retry under the short, then re-enable once it clears
    wr(OFS_HP_POWER_CTRL, 8'h80);
    faultIn.hpShort <= 1'b1;
    cyc(2);
    check("hpLimit", {6'h0, hpPowerOn, hpCurrentLimit}, 8'h03);
    rd(OFS_HP_POWER_CTRL, 8'h81);
    wr(OFS_HP_POWER_CTRL, 8'h82);
    cyc(2);
    check("hpOff", {6'h0, hpPowerOn, hpCurrentLimit}, 8'h00);
    rd(OFS_HP_POWER_CTRL, 8'h03);
    wr(OFS_HP_POWER_CTRL, 8'h82);
    cyc(2);
    check("hpRetry", {7'h0, hpPowerOn}, 8'h00);
    @(posedge clk) faultIn.hpShort <= 1'b0;
    wr(OFS_HP_POWER_CTRL, 8'h82);
    cyc(3);
    check("hpBack", {7'h0, hpPowerOn}, 8'h01);
    rd(OFS_HP_POWER_CTRL, 8'h82);
    $display("done: headphone short");
    // Speaker over-temperature pause, then overcurrent shutdown and re-enable
    wr(OFS_SPK_POWER_CTRL, 8'h80);
    cyc(2);
    check("spkOn", {6'h0, spkPowerOn, spkSwitchEn}, 8'h03);
    @(posedge clk) faultIn.overTemp <= 1'b1;
    cyc(2);
    check("otStop", {6'h0, spkPowerOn, spkSwitchEn}, 8'h02);
    wr(OFS_PAGE_SEL, PAGE_0);
    rd(OFS_OVERTEMP_FLAG, 8'h02);
    faultIn.overTemp <= 1'b0;
    wr(OFS_PAGE_SEL, PAGE_1);
    cyc(2);
    check("otGo", {6'h0, spkPowerOn, spkSwitchEn}, 8'h03);
    @(posedge clk) faultIn.spkOverCurrent <= 1'b1;
    cyc(2);
    check("spkOcp", {6'h0, spkPowerOn, spkSwitchEn}, 8'h00);
    rd(OFS_SPK_POWER_CTRL, 8'h01);
    faultIn.spkOverCurrent <= 1'b0;
    wr(OFS_SPK_POWER_CTRL, 8'h80);
    cyc(2);
    check("spkBack", {6'h0, spkPowerOn, spkSwitchEn}, 8'h03);
    rd(OFS_SPK_POWER_CTRL, 8'h80);
    $display("done: speaker faults");
    // Software reset, then pin reset with a stage powered
    wr(OFS_PAGE_SEL, PAGE_0);
    wr(OFS_SOFT_RESET, 8'h01);
    cyc(3);
    check("swRst", {3'h0, hpMute, spkMute, spkVolMuted, hpPowerOn, spkPowerOn}, 8'h1C);
    rd(OFS_VOLUME_STEP_TIME, 8'h00);
    wr(OFS_PAGE_SEL, PAGE_1);
    wr(OFS_SPK_POWER_CTRL, 8'h80);
    reset <= 1'b1;
    cyc(2);
    check("hwRst", {6'h0, spkPowerOn, hpPowerOn}, 8'h00);
    @(posedge clk) reset <= 1'b0;
    cyc(3);
    $display("done: resets");
    summarize();
  end
endmodule
